//--- common/ime_map.svh
// Register offsets, field positions and reset values of the bus target
`ifndef IME_MAP_SVH
`define IME_MAP_SVH

`define IME_AXI_AW       8
`define IME_REG_CTRL     8'h00
`define IME_REG_STATUS   8'h04
`define IME_REG_PTR      8'h08
`define IME_MEM_SEL      2'h1
`define IME_MEM_DEPTH    16
`define IME_MEM_AW       4

`define IME_CTRL_RESET   32'h00000000
`define IME_CTRL_MASK    32'h00007FFF
`define IME_CTRL_TEN     10
`define IME_CTRL_EN      11
`define IME_CTRL_IASZ    12
`define IME_CTRL_NACKD   14

`define IME_FL_START     0
`define IME_FL_STOP      1
`define IME_FL_QUICK     2
`define IME_FL_MNACK     3

`define IME_TEN_PATTERN  5'h1E
`define IME_RESP_OKAY    2'h0
`define IME_RESP_SLVERR  2'h2

`endif

//--- common/ime_pkg.sv
// Types shared by the two-wire bus target
`include "ime_map.svh"
package ime_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ack,
        st_tx,
        st_tx_ack,
        st_wait
    } ime_state_e;

    typedef enum logic [1:0] {
        rk_addr,
        rk_addr2,
        rk_data
    } ime_rxkind_e;

    typedef struct packed {
        logic [1:0]                        scl_sy;
        logic [1:0]                        sda_sy;
        logic                              scl_prev;
        logic                              sda_prev;
        ime_state_e                        st;
        ime_rxkind_e                       kind;
        ime_state_e                        ack_next;
        logic [3:0]                        cnt;
        logic [7:0]                        sh;
        logic                              drive;
        logic                              mack;
        logic                              rw;
        logic                              ten_ok;
        logic                              qual;
        logic [1:0]                        iacnt;
        logic [7:0]                        ptr;
        logic [7:0]                        nbytes;
        logic [31:0]                       ctrl;
        logic [3:0]                        flags;
        logic                              quick_val;
        logic                              aw_got;
        logic                              w_got;
        logic [`IME_AXI_AW-1:0]            awaddr;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              rvalid;
        logic [1:0]                        rresp;
        logic [31:0]                       rdata;
        logic [`IME_MEM_DEPTH-1:0][7:0]    mem;
    } ime_state_s;

endpackage

//--- rtl/ime_target.sv
// Two-wire bus target that answers the master engine, with AXI4-Lite registers
// Functional notes
// - Target answers only once software enables it and sets its own address.
// - Stop comes only from software stop command; target ends frame on it.
// - Single-byte read: start and stop commands together; target sees one byte.
// - Multi-byte read ends with master not-acknowledge, target stops sending.
// - Late stop may cause a spurious extra read; target serves it normally.
// - Zero to three internal address bytes precede data, per size field.
// - Ten-bit target: pattern 11110 plus two top bits, then low byte.
// - DMA transmit streams bytes; target accepts any number of them while nackd is clear.
// - DMA receive ends with stop and two final reads; target serves each.
// - Quick command: address-only frame, direction bit carries the command.
// - Bytes are eight bits, most significant first, then acknowledge bit.
// - Start is data falling with clock high; stop is data rising.
`include "ime_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ime_target (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    input  wire logic [`IME_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`IME_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    ime_pkg::ime_state_s s;
    ime_pkg::ime_state_s n;
    logic [3:0]          fset;
    logic [3:0]          fclr;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_det;
    logic                stop_det;
    logic                sda_now;
    logic                en;
    logic                ten;
    logic [9:0]          own;
    logic [1:0]          iasz;
    logic                nackd;

    // Word decode shared by the read and write paths
    function automatic logic is_mapped(input logic [`IME_AXI_AW-1:0] a);
        return (a[7:6] == `IME_MEM_SEL) || ({a[7:2], 2'h0} == `IME_REG_CTRL) ||
               ({a[7:2], 2'h0} == `IME_REG_STATUS) || ({a[7:2], 2'h0} == `IME_REG_PTR);
    endfunction

    function automatic logic [31:0] rd_word(input ime_pkg::ime_state_s q,
                                            input logic [`IME_AXI_AW-1:0] a);
        logic [31:0] r;
        r = 32'h00000000;
        if (a[7:6] == `IME_MEM_SEL) begin
            r = {24'h000000, q.mem[a[2 +: `IME_MEM_AW]]};
        end else begin
            case ({a[7:2], 2'h0})
                `IME_REG_CTRL:   r = q.ctrl;
                `IME_REG_STATUS: r = {16'h0000, q.nbytes, 2'h0, q.flags[`IME_FL_MNACK],
                                      q.quick_val, q.flags[2:0], q.st != ime_pkg::st_idle};
                `IME_REG_PTR:    r = {24'h000000, q.ptr};
                default:         r = 32'h00000000;
            endcase
        end
        return r;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Line events from the synchronised copies only
    assign sda_now   = s.sda_sy[1];
    assign scl_rise  = s.scl_sy[1] & ~s.scl_prev;
    assign scl_fall  = ~s.scl_sy[1] & s.scl_prev;
    assign start_det = s.scl_sy[1] & s.scl_prev & s.sda_prev & ~sda_now;
    assign stop_det  = s.scl_sy[1] & s.scl_prev & ~s.sda_prev & sda_now;
    assign en        = s.ctrl[`IME_CTRL_EN];
    assign ten       = s.ctrl[`IME_CTRL_TEN];
    assign own       = s.ctrl[9:0];
    assign iasz      = s.ctrl[`IME_CTRL_IASZ +: 2];
    assign nackd     = s.ctrl[`IME_CTRL_NACKD];

    // Handshakes come straight from state; data outputs are registered
    assign s_axi_awready = ~s.aw_got & ~s.bvalid;
    assign s_axi_wready  = ~s.w_got & ~s.bvalid;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign sda_out       = 1'b0;
    assign sda_oe_n      = ~s.drive;

    // Next state: bus slave first, line engine after so its memory writes win
    always_comb begin
        n = s;
        fset = 4'h0;
        fclr = 4'h0;
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Write takes effect once address and data are both held
        if (n.aw_got && n.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = is_mapped(n.awaddr) ? `IME_RESP_OKAY : `IME_RESP_SLVERR;
            if (n.awaddr[7:6] == `IME_MEM_SEL) begin
                if (n.wstrb[0]) begin
                    n.mem[n.awaddr[2 +: `IME_MEM_AW]] = n.wdata[7:0];
                end
            end else if ({n.awaddr[7:2], 2'h0} == `IME_REG_CTRL) begin
                n.ctrl = merge_strb(s.ctrl, n.wdata, n.wstrb) & `IME_CTRL_MASK;
            end else if ({n.awaddr[7:2], 2'h0} == `IME_REG_STATUS && n.wstrb[0]) begin
                fclr = {n.wdata[5], n.wdata[3:1]};
            end
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_word(s, s_axi_araddr);
            n.rresp  = is_mapped(s_axi_araddr) ? `IME_RESP_OKAY : `IME_RESP_SLVERR;
        end

        // Two-stage synchronisers, third stage keeps the previous level
        n.scl_sy   = {s.scl_sy[0], scl_in};
        n.sda_sy   = {s.sda_sy[0], sda_in};
        n.scl_prev = s.scl_sy[1];
        n.sda_prev = s.sda_sy[1];

        if (start_det && en) begin
            // Start or repeated start restarts address reception
            n.st    = ime_pkg::st_rx;
            n.kind  = ime_pkg::rk_addr;
            n.cnt   = 4'h0;
            n.drive = 1'b0;
            if (s.st == ime_pkg::st_idle) begin
                n.nbytes = 8'h00;
            end
            fset[`IME_FL_START] = 1'b1;
        end else if (stop_det) begin
            // Address-only frame counts as a quick command
            if (s.st != ime_pkg::st_idle) begin
                fset[`IME_FL_STOP] = 1'b1;
            end
            if (s.qual) begin
                fset[`IME_FL_QUICK] = 1'b1;
                n.quick_val = s.rw;
            end
            n.st     = ime_pkg::st_idle;
            n.drive  = 1'b0;
            n.ten_ok = 1'b0;
            n.qual   = 1'b0;
        end else begin
            case (s.st)
                ime_pkg::st_rx: begin
                    if (scl_rise) begin
                        n.sh  = {s.sh[6:0], sda_now};
                        n.cnt = s.cnt + 4'h1;
                        // A stop right after the first clock of the first data byte is still quick
                        if (s.kind == ime_pkg::rk_data && s.cnt != 4'h0) begin
                            n.qual = 1'b0;
                        end
                    end else if (scl_fall && s.cnt == 4'h8) begin
                        n.cnt      = 4'h0;
                        n.st       = ime_pkg::st_wait;
                        n.ack_next = ime_pkg::st_rx;
                        n.kind     = ime_pkg::rk_data;
                        n.iacnt    = 2'h0;
                        case (s.kind)
                            ime_pkg::rk_addr: begin
                                n.rw   = s.sh[0];
                                n.qual = 1'b0;
                                if ((!ten && s.sh[7:1] == own[6:0]) ||
                                    (ten && s.sh[7:3] == `IME_TEN_PATTERN &&
                                     s.sh[2:1] == own[9:8] && (!s.sh[0] || s.ten_ok))) begin
                                    n.st    = ime_pkg::st_ack;
                                    n.drive = 1'b1;
                                    n.qual  = 1'b1;
                                    n.ack_next = s.sh[0] ? ime_pkg::st_tx : ime_pkg::st_rx;
                                    if (ten && !s.sh[0]) begin
                                        n.kind = ime_pkg::rk_addr2;
                                    end
                                end
                            end
                            ime_pkg::rk_addr2: begin
                                n.qual = 1'b0;
                                if (s.sh == own[7:0]) begin
                                    n.st     = ime_pkg::st_ack;
                                    n.drive  = 1'b1;
                                    n.ten_ok = 1'b1;
                                    n.qual   = s.qual;
                                end
                            end
                            default: begin
                                if (s.iacnt < iasz) begin
                                    // Internal address: last byte sets the pointer
                                    n.ptr   = s.sh;
                                    n.iacnt = s.iacnt + 2'h1;
                                    n.kind  = ime_pkg::rk_data;
                                    n.st    = ime_pkg::st_ack;
                                    n.drive = 1'b1;
                                end else if (!nackd) begin
                                    // Unbounded stream; pointer wraps in memory
                                    n.mem[s.ptr[`IME_MEM_AW-1:0]] = s.sh;
                                    n.ptr    = s.ptr + 8'h01;
                                    n.nbytes = s.nbytes + 8'h01;
                                    n.iacnt  = s.iacnt;
                                    n.st     = ime_pkg::st_ack;
                                    n.drive  = 1'b1;
                                end
                            end
                        endcase
                        if (s.kind == ime_pkg::rk_data) begin
                            n.iacnt = (s.iacnt < iasz) ? s.iacnt + 2'h1 : s.iacnt;
                        end
                    end
                end
                ime_pkg::st_ack: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        n.st  = s.ack_next;
                        if (s.ack_next == ime_pkg::st_tx) begin
                            n.sh     = s.mem[s.ptr[`IME_MEM_AW-1:0]];
                            n.drive  = ~s.mem[s.ptr[`IME_MEM_AW-1:0]][7];
                            n.ptr    = s.ptr + 8'h01;
                            n.nbytes = s.nbytes + 8'h01;
                        end else begin
                            n.drive = 1'b0;
                        end
                    end
                end
                ime_pkg::st_tx: begin
                    // Quick read hazard: a first data bit of 0 blocks the stop
                    if (scl_rise) begin
                        n.cnt  = s.cnt + 4'h1;
                        if (s.cnt != 4'h0) begin
                            n.qual = 1'b0;
                        end
                    end else if (scl_fall) begin
                        if (s.cnt == 4'h8) begin
                            n.drive = 1'b0;
                            n.cnt   = 4'h0;
                            n.st    = ime_pkg::st_tx_ack;
                        end else begin
                            n.drive = ~s.sh[6];
                            n.sh    = {s.sh[6:0], 1'b0};
                        end
                    end
                end
                ime_pkg::st_tx_ack: begin
                    if (scl_rise) begin
                        n.mack = ~sda_now;
                    end else if (scl_fall) begin
                        if (s.mack) begin
                            // Extra reads after a late stop are served too
                            n.st     = ime_pkg::st_tx;
                            n.sh     = s.mem[s.ptr[`IME_MEM_AW-1:0]];
                            n.drive  = ~s.mem[s.ptr[`IME_MEM_AW-1:0]][7];
                            n.ptr    = s.ptr + 8'h01;
                            n.nbytes = s.nbytes + 8'h01;
                        end else begin
                            n.st    = ime_pkg::st_wait;
                            n.drive = 1'b0;
                            fset[`IME_FL_MNACK] = 1'b1;
                        end
                    end
                end
                ime_pkg::st_idle, ime_pkg::st_wait: begin
                    n.st = s.st;
                end
                default: begin
                    n.st = ime_pkg::st_idle;
                end
            endcase
        end
        // Hardware set wins over a same-cycle software clear
        n.flags = (s.flags & ~fclr) | fset;
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            // Line stages start at the idle-high level, so no false edge follows reset
            s.scl_sy   <= 2'h3;
            s.sda_sy   <= 2'h3;
            s.scl_prev <= 1'b1;
            s.sda_prev <= 1'b1;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence seq_byte_done;
        s.st == ime_pkg::st_rx && s.cnt == 4'h8 && scl_fall && !start_det && !stop_det;
    endsequence

    sequence seq_wait_entered;
        ##1 s.st == ime_pkg::st_wait && !s.drive;
    endsequence

    AST_START_ADDR: assert property (start_det && en |=> s.st == ime_pkg::st_rx &&
        s.kind == ime_pkg::rk_addr && s.cnt == 4'h0 && !s.drive)
        else $error("start did not restart address reception");
    AST_STOP_IDLE: assert property (stop_det && !(start_det && en) |=>
        s.st == ime_pkg::st_idle && sda_oe_n)
        else $error("stop did not end the frame");
    AST_BYTE_EIGHT: assert property (seq_byte_done |=>
        s.st == ime_pkg::st_ack || s.st == ime_pkg::st_wait)
        else $error("byte not closed after eight bits");
    AST_ACK_DRIVE: assert property (s.st == ime_pkg::st_ack |-> !sda_oe_n)
        else $error("acknowledge not driven low");
    AST_TEN_PATTERN: assert property (seq_byte_done ##0 (s.kind == ime_pkg::rk_addr &&
        ten && s.sh[7:3] != `IME_TEN_PATTERN) |-> seq_wait_entered)
        else $error("ten-bit pattern mismatch was acknowledged");
    AST_NOT_ACK_FLAG_END: assert property (s.st == ime_pkg::st_tx_ack && scl_fall && !s.mack &&
        !start_det && !stop_det |-> seq_wait_entered ##1 s.flags[`IME_FL_MNACK])
        else $error("master not-acknowledge did not end sending");
    AST_QUICK: assert property (stop_det && s.qual && !(start_det && en) |=>
        s.flags[`IME_FL_QUICK] && s.quick_val == $past(s.rw))
        else $error("quick command not recorded");
    AST_DISABLED: assert property (!en && s.st == ime_pkg::st_idle |=>
        s.st == ime_pkg::st_idle)
        else $error("disabled target left idle");
    AST_DATA_STORE: assert property (seq_byte_done ##0 (s.kind == ime_pkg::rk_data &&
        s.iacnt >= iasz && !nackd) |=> s.ptr == $past(s.ptr) + 8'h01)
        else $error("data byte did not advance the pointer");
    AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

endmodule

`default_nettype wire

//--- testbench/ime_bus_master.sv
// Behavioural two-wire bus master that drives the target's far side
`timescale 1ns/1ps
`default_nettype none

module ime_bus_master #(
    parameter int HALF = 4
) (
    input  wire logic mclk,
    output var  logic scl,
    output var  logic sda_o,
    input  wire logic sda_i
);
    // Bus idle: both lines released high, clock stands still
    initial begin
        scl   = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Clock phases from one divider, low and high halves equal
    task automatic bit_x(input logic b, output logic rb);
        scl   <= 1'b0;
        wt(HALF / 2);
        sda_o <= b;
        wt(HALF / 2);
        scl   <= 1'b1;
        wt(HALF / 2);
        rb = sda_i;
        wt(HALF / 2);
    endtask

    // Clock held low, as a master does while its holding registers wait
    task automatic hold_low(input int n);
        scl <= 1'b0;
        wt(n);
    endtask

    // Start is cond(1,0), stop is cond(0,1): data moves with clock high
    task automatic cond(input logic first, input logic last);
        scl   <= 1'b0;
        wt(HALF / 2);
        sda_o <= first;
        wt(HALF / 2);
        scl   <= 1'b1;
        wt(HALF);
        sda_o <= last;
        wt(HALF);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ab, a);
    endtask
endmodule

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the two-wire bus target
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
    typedef struct packed {
        logic [7:0]  ad;
        logic [31:0] wd;
        logic [1:0]  br;
        logic [31:0] rd;
        logic [1:0]  rr;
    } ime_row_s;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, q;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, a;
    logic        awready, wready, bvalid, arready, rvalid, sda_out, sda_oe_n, m_scl, m_sda;
    logic [1:0]  bresp, rresp, r;
    int          fail_count = 0, num_checks = 0;
    wire logic   sda_w = m_sda & (sda_oe_n | sda_out); // Wired-AND, pull-up when released
    ime_row_s    rows [4] = '{'{8'h00, 32'hFFFFFFFF, 2'h0, 32'h7FFF, 2'h0},
                              '{8'h20, 32'h12345678, 2'h2, 32'h0, 2'h2},
                              '{8'h44, 32'hA5, 2'h0, 32'hA5, 2'h0},
                              '{8'h00, 32'h182A, 2'h0, 32'h182A, 2'h0}};

    always #12.5 mclk = ~mclk;

    ime_target u_dut (.mclk(mclk), .reset_n(reset_n), .scl_in(m_scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    ime_bus_master #(.HALF(4)) u_mst (.mclk(mclk), .scl(m_scl), .sda_o(m_sda), .sda_i(sda_w));

    // Handshakes are read at the falling edge so they are settled, acted on at rising
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] br);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge mclk);
        awaddr  <= ad;
        wdata   <= wd;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!hb) begin
            @(negedge mclk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            br = bresp;
            @(posedge mclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] rr);
        logic ha, hr;
        hr = 1'b0;
        @(posedge mclk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!hr) begin
            @(negedge mclk);
            ha = arvalid & arready;
            hr = rvalid;
            rd = rdata;
            rr = rresp;
            @(posedge mclk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wb(input logic [7:0] v, input logic ea);
        u_mst.xfer(v, 1'b1, q, a);
        `CHK("ack", ea, a)
    endtask

    task automatic rb(input logic ab, input logic [7:0] ev);
        u_mst.xfer(8'hFF, ab, q, a);
        `CHK("rxbyte", ev, q)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far beyond the under two thousand cycles the frames need
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge mclk);
        `CHK("oe_n_rst", 1'b1, sda_oe_n)
        `CHK("bvalid_rst", 1'b0, bvalid)
        `CHK("sda_out_rst", 1'b0, sda_out)
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            axi_wr(rows[i].ad, rows[i].wd, r);
            `CHK("bresp", rows[i].br, r)
            axi_rd(rows[i].ad, d, r);
            `CHK("rdata", rows[i].rd, d)
            `CHK("rresp", rows[i].rr, r)
        end
        $display("test registers done");
        // Write frame: one internal address byte, then two data bytes
        u_mst.cond(1'b1, 1'b0);
        wb(8'h54, 1'b0);
        wb(8'h03, 1'b0);
        wb(8'h5C, 1'b0);
        u_mst.hold_low(40);
        wb(8'hC3, 1'b0);
        u_mst.cond(1'b0, 1'b1);
        axi_rd(8'h4C, d, r);
        `CHK("mem3", 32'h5C, d)
        axi_rd(8'h08, d, r);
        `CHK("ptr", 32'h05, d)
        axi_rd(8'h04, d, r);
        `CHK("stop_seen", 1'b1, d[2])
        // Read frame: address phase, repeated start, then ack and final not_ack_flag
        u_mst.cond(1'b1, 1'b0);
        wb(8'h54, 1'b0);
        wb(8'h03, 1'b0);
        u_mst.cond(1'b1, 1'b0);
        wb(8'h55, 1'b0);
        rb(1'b0, 8'h5C);
        u_mst.hold_low(40);
        rb(1'b1, 8'hC3);
        u_mst.cond(1'b0, 1'b1);
        axi_rd(8'h04, d, r);
        `CHK("mnack", 1'b1, d[5])
        // Wrong address must stay unacknowledged
        axi_wr(8'h04, 32'h2E, r);
        u_mst.cond(1'b1, 1'b0);
        wb(8'h56, 1'b1);
        u_mst.cond(1'b0, 1'b1);
        // Quick command with the write bit, no internal address
        axi_wr(8'h00, 32'h82A, r);
        u_mst.cond(1'b1, 1'b0);
        wb(8'h54, 1'b0);
        u_mst.cond(1'b0, 1'b1);
        axi_rd(8'h04, d, r);
        `CHK("quick", 2'b01, d[4:3])
        // Ten-bit target: write phase, read after repeated start, then a bad pattern
        axi_wr(8'h00, 32'hEA5, r);
        u_mst.cond(1'b1, 1'b0);
        wb(8'hF4, 1'b0);
        wb(8'hA5, 1'b0);
        wb(8'h66, 1'b0);
        u_mst.cond(1'b1, 1'b0);
        wb(8'hF5, 1'b0);
        rb(1'b1, 8'h00);
        u_mst.cond(1'b0, 1'b1);
        u_mst.cond(1'b1, 1'b0);
        wb(8'hE4, 1'b1);
        u_mst.cond(1'b0, 1'b1);
        axi_rd(8'h54, d, r);
        `CHK("mem5", 32'h66, d)
        $display("test frames done");
        // Reset in mid-run clears the control word and releases the line
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("oe_n_rst2", 1'b1, sda_oe_n)
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        axi_rd(8'h00, d, r);
        `CHK("ctrl_rst2", 32'h0, d)
        $display("test reset done");
        finish_test();
    end
endmodule

`default_nettype wire
